/* verilog/sqd_diag_decoder.sv */
// Diagnostic-mode message decoder with AHB-Lite status registers
// Operation
// (RL1) Mode bits one-zero mean diagnostic message
// (RL2) Whole frame carries odd parity
// (RL3) Settings applied only with write bit set
// (RL4) Diagnostic response follows every diagnostic message
// (RL5) Measure currents need D8, D9, D12, not D11
// (RL6) D11 enables switch test, D10 picks side
// (RL7) D11 low disables switch test, ignores D10
// (RL8) D9 enables current, D8 picks bias/measure
// (RL9) D9 low disables currents, ignores D8
// (RL10) Bits two to zero pick current channel
// (RL11) D7 drives monitor output, else high impedance
// (RL12) Bits six to four pick monitored channel
// (RL13) Two independent one-hot channel multiplexers
// (RL14) D3 selects calibration or resistance on monitor
// (RL15) Response D7 high when low pin below threshold
// (RL16) Reset disables everything, write bit reads zero; monitorSelect still selects channel 0 after reset
// (RL17) Host enables one monitor output at a time
// (RL18) Comparator results latched into response bits
// (RL19) Apply only at chip-select release after sixteen clocks
// (RL20) Bad parity leaves settings unchanged
//
// The AHB-Lite register port and the address map were left to the implementer.
`default_nettype none
`include "sqd_defs.svh"
module sqd_diag_decoder #(
    parameter int CHANNELS = 8,
    parameter int ERR_W = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic csDeployN,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    input wire logic [CHANNELS-1:0] groundShortBelow,
    input wire logic [CHANNELS-1:0] batteryShortAbove,
    input wire logic [CHANNELS-1:0] overCurrent,
    output logic [CHANNELS-1:0] biasTestCurrent,
    output logic [CHANNELS-1:0] measureSourceCurrent,
    output logic [CHANNELS-1:0] measureSinkCurrent,
    output logic [CHANNELS-1:0] monitorSelect,
    output logic lowSideSwitchOn,
    output logic highSideSwitchOn,
    output logic analogMonitorOe,
    output logic analogMonitorCal,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    logic shMiso, shMisoOe, frameStart, frameDone, frameFull;
    logic [15:0] rxWord, txWord;
    logic [CHANNELS-1:0] curHot, monHot;

    sqd_pkg::sqd_cfg_type cfg_r, cfg_nxt;
    sqd_pkg::sqd_stat_type stat_r, stat_nxt;
    logic write_r, write_nxt;
    logic respValid_r, respValid_nxt;
    logic [15:0] lastResp_r, lastResp_nxt;
    logic [ERR_W-1:0] errCnt_r, errCnt_nxt;
    logic frameIsDiag, parityOk;

    sqd_spi_shift u_shift (
        .core_clk(core_clk),
        .resetn(resetn),
        .csDeployN(csDeployN),
        .sclk(sclk),
        .mosi(mosi),
        .txWord(txWord),
        .miso(shMiso),
        .misoOe(shMisoOe),
        .frameStart(frameStart),
        .frameDone(frameDone),
        .frameFull(frameFull),
        .rxWord(rxWord)
    );

    sqd_chan_decode #(.SEL_W(3), .CHANNELS(CHANNELS)) u_cur_dec (
        .sel(cfg_r.curChan),
        .en(cfg_r.curEn),
        .oneHot(curHot)
    );

    sqd_chan_decode #(.SEL_W(3), .CHANNELS(CHANNELS)) u_mon_dec (
        .sel(cfg_r.monChan),
        .en(1'b1),
        .oneHot(monHot)
    );

    // Control register bits
    logic [31:0] ctrl_r, ctrl_nxt;
    logic decodeEn;
    assign decodeEn = ctrl_r[`SQD_BIT_CTRL_EN];

    // Frame decode
    assign frameIsDiag = ({rxWord[`SQD_BIT_MODE_HI], rxWord[`SQD_BIT_MODE_LO]}
        == `SQD_MODE_DIAG); // see (RL1)
    assign parityOk = ^rxWord; // see (RL2)

    // Response word mirrors settings and frozen comparator status
    assign txWord = respValid_r ? {2'b10, stat_r.batShort, write_r, cfg_r.swDiagEn,
        cfg_r.highSideSel, cfg_r.curEn, cfg_r.curMeasure, stat_r.gndBelow,
        cfg_r.monChan, stat_r.overCurrent, cfg_r.curChan} : 16'h0000; // see (RL4)

    always_comb
    begin
        cfg_nxt = cfg_r;
        write_nxt = write_r;
        respValid_nxt = respValid_r;
        lastResp_nxt = lastResp_r;
        errCnt_nxt = errCnt_r;
        stat_nxt = stat_r;
        // Status tracks comparators while chip select is high, frozen in a frame
        if (csDeployN && !frameStart)
        begin
            stat_nxt.gndBelow = |(groundShortBelow & monHot); // see (RL15) (RL18)
            stat_nxt.batShort = |(batteryShortAbove & monHot); // see (RL18)
            stat_nxt.overCurrent = |(overCurrent & monHot); // see (RL18)
        end
        if (frameStart)
        begin
            lastResp_nxt = txWord;
        end
        if (frameDone && frameFull && decodeEn) // see (RL19)
        begin
            if (!parityOk)
            begin
                errCnt_nxt = errCnt_r + ERR_W'(1); // see (RL20)
            end
            else if (frameIsDiag)
            begin
                respValid_nxt = 1'b1; // see (RL4)
                write_nxt = rxWord[`SQD_BIT_WRITE];
                if (rxWord[`SQD_BIT_WRITE]) // see (RL3)
                begin
                    cfg_nxt.swDiagEn = rxWord[`SQD_BIT_SWDIAG]; // see (RL6) (RL7)
                    cfg_nxt.highSideSel = rxWord[`SQD_BIT_HISIDE];
                    cfg_nxt.curEn = rxWord[`SQD_BIT_CUREN]; // see (RL8) (RL9)
                    cfg_nxt.curMeasure = rxWord[`SQD_BIT_CURMEAS];
                    cfg_nxt.monEn = rxWord[`SQD_BIT_MONEN]; // see (RL11)
                    cfg_nxt.monChan = rxWord[`SQD_BIT_MONCH_HI:`SQD_BIT_MONCH_LO]; // see (RL12)
                    cfg_nxt.monCal = rxWord[`SQD_BIT_MONCAL]; // see (RL14)
                    cfg_nxt.curChan = rxWord[`SQD_BIT_CURCH_HI:`SQD_BIT_CURCH_LO]; // see (RL10)
                end
            end
            else
            begin
                respValid_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_r <= '0; // see (RL16)
            write_r <= 1'b0; // see (RL16)
            respValid_r <= 1'b0;
            lastResp_r <= 16'h0000;
            errCnt_r <= '0;
            stat_r <= '0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            write_r <= write_nxt;
            respValid_r <= respValid_nxt;
            lastResp_r <= lastResp_nxt;
            errCnt_r <= errCnt_nxt;
            stat_r <= stat_nxt;
        end
    end

    // Output drivers, all registered
    logic [CHANNELS-1:0] bias_nxt, src_nxt, mon_nxt;
    logic [CHANNELS-1:0] bias_r, src_r, sink_r, mon_r;
    logic ls_nxt, hs_nxt, monOe_nxt, cal_nxt, miso_nxt, misoOe_nxt;
    logic ls_r, hs_r, monOe_r, cal_r, miso_r, misoOe_r;

    always_comb
    begin
        // One channel per multiplexer at most, both independent
        bias_nxt = (cfg_r.curMeasure) ? '0 : curHot; // see (RL8) (RL9) (RL13)
        src_nxt = (cfg_r.curMeasure && !cfg_r.swDiagEn) ? curHot : '0; // see (RL5)
        mon_nxt = monHot; // see (RL12) (RL13)
        ls_nxt = cfg_r.swDiagEn && !cfg_r.highSideSel; // see (RL6) (RL7)
        hs_nxt = cfg_r.swDiagEn && cfg_r.highSideSel; // see (RL6)
        monOe_nxt = cfg_r.monEn; // see (RL11)
        cal_nxt = cfg_r.monCal; // see (RL14)
        miso_nxt = shMiso;
        misoOe_nxt = shMisoOe;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bias_r <= '0;
            src_r <= '0;
            sink_r <= '0;
            mon_r <= '0;
            ls_r <= 1'b0;
            hs_r <= 1'b0;
            monOe_r <= 1'b0;
            cal_r <= 1'b0;
            miso_r <= 1'b0;
            misoOe_r <= 1'b0;
        end
        else
        begin
            bias_r <= bias_nxt;
            src_r <= src_nxt;
            sink_r <= src_nxt;
            mon_r <= mon_nxt;
            ls_r <= ls_nxt;
            hs_r <= hs_nxt;
            monOe_r <= monOe_nxt;
            cal_r <= cal_nxt;
            miso_r <= miso_nxt;
            misoOe_r <= misoOe_nxt;
        end
    end

    assign biasTestCurrent = bias_r;
    assign measureSourceCurrent = src_r;
    assign measureSinkCurrent = sink_r;
    assign monitorSelect = mon_r;
    assign lowSideSwitchOn = ls_r;
    assign highSideSwitchOn = hs_r;
    assign analogMonitorOe = monOe_r;
    assign analogMonitorCal = cal_r;
    assign miso = miso_r;
    assign misoOe = misoOe_r;

    // AHB-Lite slave, zero wait states, always OKAY
    logic wrPend_r, wrPend_nxt;
    logic [3:0] wrAddr_r, wrAddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic addrPhase;
    logic [31:0] rdMux;
    logic [31:0] addrFull;
    logic addrHit;

    assign addrPhase = hsel && htrans[1] && hready;
    // Upper address bits must be zero, else no register is hit
    assign addrHit = (haddr[31:4] == 28'h0000000);
    assign addrFull = {28'h0000000, haddr[3:0] & `SQD_ADDR_LSBS};

    always_comb
    begin
        if (!addrHit)
        begin
            rdMux = 32'h0000_0000;
        end
        else if (addrFull == `SQD_OFS_CTRL)
        begin
            rdMux = ctrl_r;
        end
        else if (addrFull == `SQD_OFS_CFG)
        begin
            rdMux = {19'h00000, write_r, cfg_r};
        end
        else if (addrFull == `SQD_OFS_RESP)
        begin
            rdMux = {respValid_r, 15'h0000, lastResp_r};
        end
        else if (addrFull == `SQD_OFS_ERR)
        begin
            rdMux = {{(32 - ERR_W){1'b0}}, errCnt_r};
        end
        else
        begin
            rdMux = 32'h0000_0000;
        end
    end

    always_comb
    begin
        wrPend_nxt = 1'b0;
        wrAddr_nxt = wrAddr_r;
        hrdata_nxt = hrdata_r;
        ctrl_nxt = ctrl_r;
        if (wrPend_r && ({28'h0000000, wrAddr_r} == `SQD_OFS_CTRL))
        begin
            ctrl_nxt = {31'h00000000, hwdata[`SQD_BIT_CTRL_EN]};
        end
        if (addrPhase)
        begin
            wrPend_nxt = hwrite && addrHit;
            wrAddr_nxt = haddr[3:0];
            hrdata_nxt = hwrite ? 32'h0000_0000 : rdMux;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 4'h0;
            hrdata_r <= 32'h0000_0000;
            ctrl_r <= `SQD_CTRL_RESET;
        end
        else
        begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            hrdata_r <= hrdata_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    logic unusedBits;
    assign unusedBits = ^{haddr[31:4], hsize, hwdata[31:1]};
endmodule : sqd_diag_decoder
`default_nettype wire

/* verilog/sqd_defs.svh */
// Offsets, field positions and reset values of the diagnostic decoder
`ifndef SQD_DEFS_SVH
`define SQD_DEFS_SVH

`define SQD_FRAME_BITS 16
`define SQD_BIT_MODE_HI 15
`define SQD_BIT_MODE_LO 14
`define SQD_MODE_DIAG 2'b10
`define SQD_BIT_WRITE 12
`define SQD_BIT_SWDIAG 11
`define SQD_BIT_HISIDE 10
`define SQD_BIT_CUREN 9
`define SQD_BIT_CURMEAS 8
`define SQD_BIT_MONEN 7
`define SQD_BIT_MONCH_HI 6
`define SQD_BIT_MONCH_LO 4
`define SQD_BIT_MONCAL 3
`define SQD_BIT_CURCH_HI 2
`define SQD_BIT_CURCH_LO 0
`define SQD_BIT_RSP_BAT 13
`define SQD_BIT_RSP_GND 7
`define SQD_BIT_RSP_OC 3

`define SQD_OFS_CTRL 32'h0000_0000
`define SQD_OFS_CFG 32'h0000_0004
`define SQD_OFS_RESP 32'h0000_0008
`define SQD_OFS_ERR 32'h0000_000c
`define SQD_ADDR_LSBS 4'hf
`define SQD_CTRL_RESET 32'h0000_0001
`define SQD_BIT_CTRL_EN 0

`endif

/* verilog/sqd_pkg.sv */
// Types shared by the diagnostic decoder modules
`default_nettype none
package sqd_pkg;
    typedef struct packed {
        logic swDiagEn;
        logic highSideSel;
        logic curEn;
        logic curMeasure;
        logic monEn;
        logic [2:0] monChan;
        logic monCal;
        logic [2:0] curChan;
    } sqd_cfg_type;

    typedef struct packed {
        logic batShort;
        logic gndBelow;
        logic overCurrent;
    } sqd_stat_type;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b01,
        SPI_ACTIVE = 2'b10
    } sqd_spi_state_type;
endpackage : sqd_pkg
`default_nettype wire

/* verilog/sqd_chan_decode.sv */
// Binary channel number to one-hot channel select
`default_nettype none
module sqd_chan_decode #(
    parameter int SEL_W = 3,
    parameter int CHANNELS = 8
) (
    input wire logic [SEL_W-1:0] sel,
    input wire logic en,
    output logic [CHANNELS-1:0] oneHot
);
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_chan
            assign oneHot[i] = en && (sel == SEL_W'(i));
        end
    endgenerate
endmodule : sqd_chan_decode
`default_nettype wire

/* verilog/sqd_spi_shift.sv */
// Serial frame shifter for the deployment chip select
`default_nettype none
`include "sqd_defs.svh"
module sqd_spi_shift (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic csDeployN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic [15:0] txWord,
    output logic miso,
    output logic misoOe,
    output logic frameStart,
    output logic frameDone,
    output logic frameFull,
    output logic [15:0] rxWord
);
    sqd_pkg::sqd_spi_state_type state_r, state_nxt;
    logic sclk_r, sclk_nxt;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic start_r, start_nxt, done_r, done_nxt, full_r, full_nxt;
    logic sclkRise, sclkFall;

    assign sclkRise = sclk && !sclk_r;
    assign sclkFall = !sclk && sclk_r;

    always_comb
    begin
        state_nxt = state_r;
        sclk_nxt = sclk;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        cnt_nxt = cnt_r;
        start_nxt = 1'b0;
        done_nxt = 1'b0;
        full_nxt = full_r;
        case (state_r)
            sqd_pkg::SPI_IDLE:
            begin
                if (!csDeployN)
                begin
                    state_nxt = sqd_pkg::SPI_ACTIVE;
                    tx_nxt = txWord;
                    cnt_nxt = 5'h00;
                    start_nxt = 1'b1;
                end
            end
            sqd_pkg::SPI_ACTIVE:
            begin
                if (csDeployN)
                begin
                    state_nxt = sqd_pkg::SPI_IDLE;
                    done_nxt = 1'b1;
                    full_nxt = (cnt_r == 5'(`SQD_FRAME_BITS)); // see (RL19)
                end
                else
                begin
                    if (sclkRise)
                    begin
                        rx_nxt = {rx_r[14:0], mosi};
                        if (cnt_r <= 5'(`SQD_FRAME_BITS))
                        begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                    end
                    if (sclkFall)
                    begin
                        tx_nxt = {tx_r[14:0], 1'b0};
                    end
                end
            end
            default:
            begin
                state_nxt = sqd_pkg::SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= sqd_pkg::SPI_IDLE;
            sclk_r <= 1'b0;
            rx_r <= 16'h0000;
            tx_r <= 16'h0000;
            cnt_r <= 5'h00;
            start_r <= 1'b0;
            done_r <= 1'b0;
            full_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sclk_r <= sclk_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            cnt_r <= cnt_nxt;
            start_r <= start_nxt;
            done_r <= done_nxt;
            full_r <= full_nxt;
        end
    end

    assign miso = tx_r[15];
    assign misoOe = (state_r == sqd_pkg::SPI_ACTIVE);
    assign frameStart = start_r;
    assign frameDone = done_r;
    assign frameFull = full_r;
    assign rxWord = rx_r;
endmodule : sqd_spi_shift
`default_nettype wire

/* testbench/sqd_diag_decoder_checker.sv */
// Port-level assertions for the diagnostic decoder
`default_nettype none
module sqd_diag_decoder_checker #(
    parameter int CHANNELS = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic csDeployN,
    input wire logic misoOe,
    input wire logic [CHANNELS-1:0] biasTestCurrent,
    input wire logic [CHANNELS-1:0] measureSourceCurrent,
    input wire logic [CHANNELS-1:0] measureSinkCurrent,
    input wire logic [CHANNELS-1:0] monitorSelect,
    input wire logic lowSideSwitchOn,
    input wire logic highSideSwitchOn,
    input wire logic analogMonitorOe,
    input wire logic analogMonitorCal,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic [3:0] lowCnt_r;
    logic [3:0] lowCnt_nxt;

    // Cycles since chip select went low, saturating
    always_comb
    begin
        lowCnt_nxt = lowCnt_r;
        if (csDeployN)
            lowCnt_nxt = 4'h0;
        else if (lowCnt_r != 4'hf)
            lowCnt_nxt = lowCnt_r + 4'h1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            lowCnt_r <= 4'h0;
        else
            lowCnt_r <= lowCnt_nxt;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    property p_sinkEq;
        measureSourceCurrent == measureSinkCurrent;
    endproperty
    a_sinkEq: assert property (p_sinkEq)
        else $error("source and sink currents differ");
    property p_curOne;
        $onehot0(biasTestCurrent | measureSourceCurrent)
            && !((|biasTestCurrent) && (|measureSourceCurrent));
    endproperty
    a_curOne: assert property (p_curOne)
        else $error("current reaches more than one channel");
    property p_monOne;
        $past(resetn, 2) |-> $onehot(monitorSelect);
    endproperty
    a_monOne: assert property (p_monOne)
        else $error("monitor select not one-hot");
    property p_swExcl;
        !(lowSideSwitchOn && highSideSwitchOn);
    endproperty
    a_swExcl: assert property (p_swExcl)
        else $error("both switches on");
    property p_measSw;
        (|measureSourceCurrent) |-> !lowSideSwitchOn && !highSideSwitchOn;
    endproperty
    a_measSw: assert property (p_measSw)
        else $error("measure current with switch test");
    property p_applyAtEnd;
        $changed({biasTestCurrent, measureSourceCurrent, monitorSelect, lowSideSwitchOn,
            highSideSwitchOn, analogMonitorOe, analogMonitorCal}) |-> lowCnt_r < 4'h6;
    endproperty
    a_applyAtEnd: assert property (p_applyAtEnd)
        else $error("settings changed inside a frame");
    property p_oeOn;
        $fell(csDeployN) |-> ##[1:3] misoOe;
    endproperty
    a_oeOn: assert property (p_oeOn)
        else $error("response drive late");
    property p_oeOff;
        $rose(csDeployN) |-> ##[1:3] !misoOe;
    endproperty
    a_oeOff: assert property (p_oeOff)
        else $error("response drive not released");
    property p_rstVal;
        $rose(resetn) |-> ##3 biasTestCurrent == 0 && measureSourceCurrent == 0
            && !lowSideSwitchOn && !highSideSwitchOn && !analogMonitorOe
            && !analogMonitorCal && monitorSelect == 1;
    endproperty
    a_rstVal: assert property (p_rstVal)
        else $error("wrong state after reset");
    property p_bus;
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus not ready or error");
endmodule : sqd_diag_decoder_checker

bind sqd_diag_decoder sqd_diag_decoder_checker #(.CHANNELS(CHANNELS)) i_chk (.core_clk,
    .resetn, .csDeployN, .misoOe, .biasTestCurrent, .measureSourceCurrent,
    .measureSinkCurrent, .monitorSelect, .lowSideSwitchOn, .highSideSwitchOn,
    .analogMonitorOe, .analogMonitorCal, .hreadyout, .hresp);
`default_nettype wire

/* testbench/sqd_spi_host.sv */
// Host SPI master model sending diagnostic frames
`default_nettype none
module sqd_spi_host (
    input wire logic core_clk,
    input wire logic miso,
    output logic csDeployN,
    output logic sclk,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    // Sole device on the converter input
    initial
    begin
        csDeployN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    task automatic send(input logic [1:0] md, input logic [12:0] b, input logic bad,
        input int n, output logic [15:0] rx);
        logic [15:0] w;
        w = {md, (~(^{md, b})) ^ bad, b};
        rx = 16'h0000;
        @(posedge core_clk);
        csDeployN <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 15; i > 15 - n; i--)
        begin
            mosi <= w[i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            rx[i] = miso;
            repeat (3) @(posedge core_clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
        csDeployN <= 1'b1;
        mosi <= ~mosi;
        repeat (6) @(posedge core_clk);
    endtask : send
endmodule : sqd_spi_host
`default_nettype wire

/* testbench/sqd_diag_decoder_test.sv */
// Self-checking bench for the diagnostic decoder
`default_nettype none
`include "sqd_defs.svh"
module sqd_diag_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, resetn, csDeployN, sclk, mosi, miso, misoOe;
    logic [7:0] groundShortBelow, batteryShortAbove, overCurrent;
    logic [7:0] biasTestCurrent, measureSourceCurrent, measureSinkCurrent, monitorSelect;
    logic lowSideSwitchOn, highSideSwitchOn, analogMonitorOe, analogMonitorCal;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] rx;
    logic [12:0] cfgB = 13'h0000;
    logic wrBit = 1'b0;
    logic seen = 1'b0;
    int num_errors = 0;
    int compares = 0;
    localparam logic [12:0] MODES [5] = '{13'h1302, 13'h1b03, 13'h1d84, 13'h0e55, 13'h1000};

    assign hready = hreadyout;
    sqd_diag_decoder i_dut (.core_clk, .resetn, .csDeployN, .sclk, .mosi, .miso, .misoOe,
        .groundShortBelow, .batteryShortAbove, .overCurrent, .biasTestCurrent,
        .measureSourceCurrent, .measureSinkCurrent, .monitorSelect, .lowSideSwitchOn,
        .highSideSwitchOn, .analogMonitorOe, .analogMonitorCal, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp);
    sqd_spi_host i_host (.core_clk, .miso, .csDeployN, .sclk, .mosi);

    task close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task outs;
        logic [7:0] c;
        logic m;
        logic [23:0] gotCur, expCur;
        logic [11:0] gotSw, expSw;
        c = 8'h01 << cfgB[2:0];
        m = cfgB[9] & cfgB[8] & !cfgB[11];
        gotCur = {biasTestCurrent, measureSourceCurrent, measureSinkCurrent};
        expCur = {(cfgB[9] & !cfgB[8]) ? c : 8'h00, m ? c : 8'h00, m ? c : 8'h00};
        gotSw = {monitorSelect, lowSideSwitchOn, highSideSwitchOn, analogMonitorOe,
            analogMonitorCal};
        expSw = {8'h01 << cfgB[6:4], cfgB[11] & !cfgB[10], cfgB[11] & cfgB[10], cfgB[7], cfgB[3]};
        chk(gotCur, expCur);
        chk(gotSw, expSw);
    endtask : outs

    task xf(input logic [1:0] md, input logic [12:0] b, input logic bad, input int n);
        logic [2:0] m;
        m = cfgB[6:4];
        i_host.send(md, b, bad, n, rx);
        if (n == 16)
            chk(rx, seen ? {2'b10, batteryShortAbove[m], wrBit, cfgB[11:8], groundShortBelow[m],
                m, overCurrent[m], cfgB[2:0]} : 16'h0000);
        if (!bad && n == 16)
        begin
            seen = (md == 2'b10);
            wrBit = b[12];
            if (seen && b[12])
                cfgB = b;
        end
        outs();
    endtask : xf

    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb

    task rdchk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rd);
        chk(rd, e);
    endtask : rdchk

    task t_reset;
        outs();
        rdchk(`SQD_OFS_CTRL, `SQD_CTRL_RESET);
        rdchk(`SQD_OFS_ERR, 32'h0);
        xf(2'b10, 13'h0000, 1'b0, 16);
    endtask : t_reset

    task t_chan;
        for (int i = 0; i < 8; i++)
        begin
            groundShortBelow <= 8'ha5 ^ 8'(i);
            xf(2'b10, {5'b10010, 1'b1, ~3'(i), i[0], 3'(i)}, 1'b0, 16);
        end
    endtask : t_chan

    task t_modes;
        for (int i = 0; i < 5; i++)
            xf(2'b10, MODES[i], 1'b0, 16);
    endtask : t_modes

    task t_refuse;
        xf(2'b10, 13'h1fff, 1'b1, 16);
        rdchk(`SQD_OFS_ERR, 32'h1);
        xf(2'b10, 13'h1fff, 1'b0, 15);
        xf(2'b01, 13'h1fff, 1'b0, 16);
        xf(2'b10, 13'h1abc, 1'b0, 16);
    endtask : t_refuse

    task t_bus;
        rdchk(`SQD_OFS_RESP, {1'b1, 15'h0000, rx});
        rdchk(`SQD_OFS_CFG, {19'h0, wrBit, cfgB[11:0]});
        rdchk(32'h0000_0010, 32'h0);
        ahb(1'b1, `SQD_OFS_ERR, 32'hff, rd);
        rdchk(`SQD_OFS_ERR, 32'h1);
        ahb(1'b1, `SQD_OFS_CTRL, 32'h0, rd);
        rdchk(`SQD_OFS_CTRL, 32'h0);
        i_host.send(2'b10, 13'h1000, 1'b0, 16, rx);
        outs();
        ahb(1'b1, `SQD_OFS_CTRL, 32'h1, rd);
        rdchk(`SQD_OFS_CTRL, 32'h1);
        ahb(1'b1, 32'h0000_0010, 32'h0, rd);
        rdchk(`SQD_OFS_CTRL, 32'h1);
    endtask : t_bus

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial
    begin
        #300us;
        num_errors++;
        close_out();
    end

    initial
    begin
        resetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        groundShortBelow = 8'h00;
        batteryShortAbove = 8'h3c;
        overCurrent = 8'h81;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_chan();
        t_modes();
        t_refuse();
        t_bus();
        close_out();
    end
endmodule : sqd_diag_decoder_test
`default_nettype wire
